// ===== step_indexer_pkg.sv
/*
  Shared constants, types and lookup helpers for the step indexer.
  Assumes a single 200 MHz clock domain; all pin levels arrive synchronous to it.
*/
package step_indexer_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ            = 200;
  localparam int unsigned SLEEP_ENTER_US     = 100;  // least time before power saving
  localparam int unsigned WAKE_MAX_MS        = 10;   // longest time to resume
  localparam int unsigned SLEEP_ENTER_CYCLES = SLEEP_ENTER_US * CLK_MHZ;
  localparam int unsigned WAKE_MAX_CYCLES    = WAKE_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned PHASE_CNT_W        = 21;

  // register map (byte addresses)
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] CURRENT_OFFSET = 8'h08;
  localparam logic [7:0] FAULT_OFFSET   = 8'h0C;

  // field positions
  localparam int CTRL_SOFT_OFF_BIT   = 0;
  localparam int STAT_POS_LSB        = 0;
  localparam int STAT_SAVING_BIT     = 7;
  localparam int STAT_NORMAL_BIT     = 8;
  localparam int STAT_DRIVE_BIT      = 9;
  localparam int STAT_FORCED_BIT     = 10;
  localparam int STAT_MONITOR_BIT    = 11;
  localparam int STAT_DIR_BIT        = 12;
  localparam int CUR_A_LSB           = 0;
  localparam int CUR_B_LSB           = 8;
  localparam int FAULT_TEMP_BIT      = 0;
  localparam int FAULT_CURRENT_BIT   = 1;

  // reset values
  localparam logic       CTRL_SOFT_OFF_RESET = 1'b0;
  localparam logic [6:0] ANGLE_INIT          = 7'h00;

  // current levels in percent
  localparam logic signed [7:0] PCT_FULL = 8'sh64;

  // cosine magnitude over one quarter cycle, 32 fine steps
  localparam logic [6:0] COS_TABLE [0:32] = '{
    7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61, 7'h60, 7'h5E,
    7'h5C, 7'h5A, 7'h58, 7'h56, 7'h53, 7'h50, 7'h4D, 7'h4A,
    7'h47, 7'h43, 7'h3F, 7'h3C, 7'h38, 7'h33, 7'h2F, 7'h2B,
    7'h26, 7'h22, 7'h1D, 7'h18, 7'h14, 7'h0F, 7'h0A, 7'h05,
    7'h00};

  typedef enum logic [2:0] {
    RES_FULL, RES_HALF_A, RES_HALF_B, RES_QUARTER, RES_EIGHTH, RES_SIXTEENTH, RES_THIRTYSECOND
  } resolution_t;

  typedef enum logic [1:0] {ST_AWAKE, ST_ENTERING, ST_ASLEEP, ST_WAKING} sleep_state_t;

  typedef struct packed {
    logic signed [7:0] a;
    logic signed [7:0] b;
  } winding_current_t;

  // fine steps per host step for each resolution
  function automatic logic [6:0] step_size(input resolution_t res);
    case (res)
      RES_FULL:      step_size = 7'h20;
      RES_HALF_A:    step_size = 7'h10;
      RES_HALF_B:    step_size = 7'h10;
      RES_QUARTER:   step_size = 7'h08;
      RES_EIGHTH:    step_size = 7'h04;
      RES_SIXTEENTH: step_size = 7'h02;
      default:       step_size = 7'h01;
    endcase
  endfunction : step_size

  // signed cosine percentage at a fine angle index
  function automatic logic signed [7:0] cos_pct(input logic [6:0] p);
    logic [5:0] idx;
    logic [7:0] mag;
    idx = p[5] ? 6'(6'h20 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
    mag = {1'b0, COS_TABLE[idx]};
    cos_pct = (p[6] ^ p[5]) ? -$signed(mag) : $signed(mag);
  endfunction : cos_pct

endpackage : step_indexer_pkg

// ===== stepper_step_indexer.sv
/*
  Step indexer for a two-phase bipolar driver: step/direction pins, sleep sequencing,
  fault latching, winding current lookup and an APB slave for control and status.
  Assumes all pins are synchronous to ref_clk and the host keeps direction and
  resolution stable around each step edge.
*/
// The register offsets and the APB slave port were chosen for this implementation.
// Notes on behaviour
// - power saving starts once sleep request has been low for 100 us
// - normal operation returns at most 10 ms after sleep request goes high
// - passing through sleep clears the latched overtemp and overcurrent forced-off state
// - charge pump and logic regulator stop while sleep request is low
// - each rising step edge while awake advances the angle by one step of resolution
// - falling step edge leaves the angle untouched
// - enable high turns the output stage on for current control
// - enable low turns every output transistor off, outputs float
// - direction high steps forward, low steps in reverse
// - first select bit low: full, half a, half b, quarter
// - first select bit high: eighth, sixteenth, then thirty-second for both rest
// - thirty-second table follows cosine for A and sine for B
// - coarser resolutions use every second, fourth, eighth or sixteenth index
// - index 16: half b gives 71 percent, half a and full 100
// - angle monitor is an open-drain output needing an external pull-up
// - reset input returns the angle to its initial index
// - a detected overtemp or overcurrent shows on the fault flag
module stepper_step_indexer #(
  parameter int unsigned SLEEP_CYCLES = step_indexer_pkg::SLEEP_ENTER_CYCLES,
  parameter int unsigned WAKE_CYCLES  = step_indexer_pkg::WAKE_MAX_CYCLES
) (
  input  wire logic                                ref_clk,                // 200 MHz clock
  input  wire logic                                resetn,                 // async reset, low
  input  wire logic                                step_in,                // step pulse level
  input  wire logic                                direction_select,       // high forward
  input  wire logic                                output_enable,          // high drives windings
  input  wire logic                                sleep_req_n,            // low requests sleep
  input  wire logic                                angle_reset,            // high reinitialises angle
  input  wire logic                                resolution_select_bit0, // first select bit
  input  wire logic                                resolution_select_bit1, // second select bit
  input  wire logic                                resolution_select_bit2, // third select bit
  input  wire logic                                overtemp_shutdown,      // thermal detector
  input  wire logic                                overcurrent_shutdown,   // current detector
  input  wire logic                                angle_monitor_in,       // monitor pin level
  output logic                                     angle_monitor_out,      // monitor pin value
  output logic                                     angle_monitor_oe,       // monitor pull-low enable
  output logic                                     fault_flag,             // high on latched fault
  output logic                                     output_stage_on,        // transistors on
  output logic                                     charge_pump_on,         // pump running
  output logic                                     regulator_on,           // logic supply running
  output logic                                     power_saving,           // in power saving mode
  output step_indexer_pkg::winding_current_t       winding_current,        // signed percent
  output logic [6:0]                               angle_position,         // fine angle index
  input  wire logic                                psel,                   // apb select
  input  wire logic                                penable,                // apb enable
  input  wire logic                                pwrite,                 // apb write
  input  wire logic [7:0]                          paddr,                  // apb byte address
  input  wire logic [31:0]                         pwdata,                 // apb write data
  output logic [31:0]                              prdata,                 // apb read data
  output logic                                     pready,                 // apb ready
  output logic                                     pslverr                 // apb error
);

  logic                                 rst_meta;
  logic                                 rst_n;
  step_indexer_pkg::sleep_state_t       state;
  step_indexer_pkg::sleep_state_t       next_state;
  logic [step_indexer_pkg::PHASE_CNT_W-1:0] phase_cnt;
  logic [step_indexer_pkg::PHASE_CNT_W-1:0] next_phase_cnt;
  logic                                 step_prev;
  logic                                 temp_latch;
  logic                                 current_latch;
  logic                                 soft_off;
  step_indexer_pkg::resolution_t        mode;
  step_indexer_pkg::winding_current_t   next_current;

  // reset release through two flops; async assert, sync release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // resolution decode, first select bit picks coarse or fine group
  always_comb begin
    case ({resolution_select_bit0, resolution_select_bit1, resolution_select_bit2})
      3'h0:    mode = step_indexer_pkg::RES_FULL;
      3'h1:    mode = step_indexer_pkg::RES_HALF_A;
      3'h2:    mode = step_indexer_pkg::RES_HALF_B;
      3'h3:    mode = step_indexer_pkg::RES_QUARTER;
      3'h4:    mode = step_indexer_pkg::RES_EIGHTH;
      3'h5:    mode = step_indexer_pkg::RES_SIXTEENTH;
      default: mode = step_indexer_pkg::RES_THIRTYSECOND;
    endcase
  end

  // sleep sequencing; a short low pulse that ends before power saving never clears faults
  always_comb begin
    next_state     = state;
    next_phase_cnt = phase_cnt + 21'h000001;
    case (state)
      step_indexer_pkg::ST_AWAKE: begin
        next_phase_cnt = '0;
        if (!sleep_req_n) begin
          next_state = step_indexer_pkg::ST_ENTERING;
        end
      end
      step_indexer_pkg::ST_ENTERING: begin
        if (sleep_req_n) begin
          next_state     = step_indexer_pkg::ST_AWAKE;
          next_phase_cnt = '0;
        end else if (phase_cnt == 21'(SLEEP_CYCLES - 1)) begin
          next_state     = step_indexer_pkg::ST_ASLEEP;
          next_phase_cnt = '0;
        end
      end
      step_indexer_pkg::ST_ASLEEP: begin
        next_phase_cnt = '0;
        if (sleep_req_n) begin
          next_state = step_indexer_pkg::ST_WAKING;
        end
      end
      step_indexer_pkg::ST_WAKING: begin
        if (!sleep_req_n) begin
          next_state     = step_indexer_pkg::ST_ENTERING;
          next_phase_cnt = '0;
        end else if (phase_cnt == 21'(WAKE_CYCLES - 1)) begin
          next_state     = step_indexer_pkg::ST_AWAKE;
          next_phase_cnt = '0;
        end
      end
      default: begin
        next_state     = step_indexer_pkg::ST_AWAKE;
        next_phase_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= step_indexer_pkg::ST_AWAKE;
      phase_cnt <= '0;
    end else begin
      state     <= next_state;
      phase_cnt <= next_phase_cnt;
    end
  end

  // supplies stop at once on a low request, before power saving is reached
  assign charge_pump_on = sleep_req_n && (state != step_indexer_pkg::ST_ASLEEP);
  assign regulator_on   = sleep_req_n && (state != step_indexer_pkg::ST_ASLEEP);
  assign power_saving   = (state == step_indexer_pkg::ST_ASLEEP);

  // fault latches; a detector still active while asleep wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_latch    <= 1'b0;
      current_latch <= 1'b0;
    end else begin
      temp_latch    <= overtemp_shutdown | (temp_latch & ~power_saving);
      current_latch <= overcurrent_shutdown | (current_latch & ~power_saving);
    end
  end

  assign fault_flag = temp_latch | current_latch;

  // output stage: pin enable, awake, no forced-off fault, no software override
  assign output_stage_on = output_enable && (state == step_indexer_pkg::ST_AWAKE) && !fault_flag && !soft_off;

  // step edge detection and angle update
  wire       step_rise = step_in & ~step_prev;
  wire [6:0] step_amt  = step_indexer_pkg::step_size(mode);
  wire       can_step  = step_rise && (state == step_indexer_pkg::ST_AWAKE);
  wire [6:0] fwd_pos   = angle_position + step_amt;
  wire [6:0] rev_pos   = angle_position - step_amt;

  // sleep also reinitialises the angle since the logic supply was off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev      <= 1'b0;
      angle_position <= step_indexer_pkg::ANGLE_INIT;
    end else begin
      step_prev <= step_in;
      if (angle_reset || power_saving) begin
        angle_position <= step_indexer_pkg::ANGLE_INIT;
      end else if (can_step) begin
        angle_position <= direction_select ? fwd_pos : rev_pos;
      end
    end
  end

  // lookup on the index snapped to the mode grid, so a mode change mid-cycle stays on table
  wire [6:0]         grid_pos  = angle_position & ~(step_amt - 7'h01);
  wire               is_full   = (mode == step_indexer_pkg::RES_FULL);
  wire [6:0]         look_pos  = is_full ? {angle_position[6:5], 5'h10} : grid_pos;
  wire               boost     = is_full || ((mode == step_indexer_pkg::RES_HALF_A) && grid_pos[4]);
  wire signed [7:0]  cos_val   = step_indexer_pkg::cos_pct(look_pos);
  wire signed [7:0]  sin_val   = step_indexer_pkg::cos_pct(7'(look_pos - 7'h20));

  always_comb begin
    next_current.a = cos_val;
    next_current.b = sin_val;
    if (boost) begin
      next_current.a = cos_val[7] ? -step_indexer_pkg::PCT_FULL : step_indexer_pkg::PCT_FULL;
      next_current.b = sin_val[7] ? -step_indexer_pkg::PCT_FULL : step_indexer_pkg::PCT_FULL;
    end
  end

  // currents and monitor registered; monitor only pulls low, the pull-up makes the high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      winding_current  <= '0;
      angle_monitor_oe <= 1'b0;
    end else begin
      winding_current  <= next_current;
      angle_monitor_oe <= (grid_pos == step_indexer_pkg::ANGLE_INIT);
    end
  end

  assign angle_monitor_out = 1'b0;

  // apb decode; zero wait states, prdata captured in the setup phase
  wire sel_ctrl    = (paddr == step_indexer_pkg::CONTROL_OFFSET);
  wire sel_status  = (paddr == step_indexer_pkg::STATUS_OFFSET);
  wire sel_current = (paddr == step_indexer_pkg::CURRENT_OFFSET);
  wire sel_fault   = (paddr == step_indexer_pkg::FAULT_OFFSET);
  wire mapped      = sel_ctrl | sel_status | sel_current | sel_fault;
  wire setup_phase = psel & ~penable;
  wire ctrl_write  = psel & penable & pwrite & sel_ctrl;

  logic [31:0] status_word;
  logic [31:0] current_word;
  logic [31:0] fault_word;
  logic [31:0] read_word;

  always_comb begin
    status_word = '0;
    status_word[step_indexer_pkg::STAT_POS_LSB +: 7] = angle_position;
    status_word[step_indexer_pkg::STAT_SAVING_BIT]   = power_saving;
    status_word[step_indexer_pkg::STAT_NORMAL_BIT]   = (state == step_indexer_pkg::ST_AWAKE);
    status_word[step_indexer_pkg::STAT_DRIVE_BIT]    = output_stage_on;
    status_word[step_indexer_pkg::STAT_FORCED_BIT]   = fault_flag;
    status_word[step_indexer_pkg::STAT_MONITOR_BIT]  = angle_monitor_in;
    status_word[step_indexer_pkg::STAT_DIR_BIT]      = direction_select;
    current_word = '0;
    current_word[step_indexer_pkg::CUR_A_LSB +: 8] = winding_current.a;
    current_word[step_indexer_pkg::CUR_B_LSB +: 8] = winding_current.b;
    fault_word = '0;
    fault_word[step_indexer_pkg::FAULT_TEMP_BIT]    = temp_latch;
    fault_word[step_indexer_pkg::FAULT_CURRENT_BIT] = current_latch;
    read_word = '0;
    if (sel_ctrl) begin
      read_word[step_indexer_pkg::CTRL_SOFT_OFF_BIT] = soft_off;
    end else if (sel_status) begin
      read_word = status_word;
    end else if (sel_current) begin
      read_word = current_word;
    end else if (sel_fault) begin
      read_word = fault_word;
    end
  end

  assign pready = 1'b1;

  // register updates and read capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_off <= step_indexer_pkg::CTRL_SOFT_OFF_RESET;
      prdata   <= '0;
      pslverr  <= 1'b0;
    end else begin
      if (ctrl_write) begin
        soft_off <= pwdata[step_indexer_pkg::CTRL_SOFT_OFF_BIT];
      end
      if (setup_phase) begin
        prdata  <= read_word;
        pslverr <= ~mapped;
      end
    end
  end

  // assertion helpers: cycles spent low before power saving, cycles spent waking
  logic [21:0] low_run;
  logic [21:0] wake_run;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_run  <= '0;
      wake_run <= '0;
    end else begin
      low_run  <= sleep_req_n ? 22'h000000 : ((low_run == 22'h3FFFFF) ? low_run : low_run + 22'h000001);
      wake_run <= (state == step_indexer_pkg::ST_WAKING) ? wake_run + 22'h000001 : 22'h000000;
    end
  end

  sleep_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(power_saving) |-> (low_run >= 22'(SLEEP_CYCLES)))
    else $error("power saving entered too early");

  wake_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wake_run <= 22'(WAKE_CYCLES))
    else $error("wake took too long");

  fault_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (power_saving && !overtemp_shutdown && !overcurrent_shutdown) |=> !fault_flag)
    else $error("fault not cleared by sleep");

  supply_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sleep_req_n |-> (!charge_pump_on && !regulator_on))
    else $error("supplies running during sleep request");

  step_advance_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (can_step && !angle_reset && direction_select) |=> (angle_position == 7'($past(angle_position) + $past(step_amt))))
    else $error("forward step wrong");

  step_reverse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (can_step && !angle_reset && !direction_select) |=> (angle_position == 7'($past(angle_position) - $past(step_amt))))
    else $error("reverse step wrong");

  fall_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!step_rise && !angle_reset && !power_saving) |=> $stable(angle_position))
    else $error("angle moved without rising edge");

  drive_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !output_enable |-> !output_stage_on)
    else $error("outputs on while disabled");

  drive_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (output_enable && !fault_flag && !soft_off && (state == step_indexer_pkg::ST_AWAKE)) |-> output_stage_on)
    else $error("outputs off while enabled");

  reset_pos_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    angle_reset |=> (angle_position == step_indexer_pkg::ANGLE_INIT))
    else $error("angle not reinitialised");

  fault_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (overtemp_shutdown || overcurrent_shutdown) |=> fault_flag)
    else $error("fault not flagged");

  fine_table_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode == step_indexer_pkg::RES_THIRTYSECOND && angle_position == 7'h08)
      |=> (winding_current.a == 8'sh5C && winding_current.b == 8'sh26))
    else $error("fine table entry wrong");

  half_b_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode == step_indexer_pkg::RES_HALF_B && angle_position == 7'h10)
      |=> (winding_current.a == 8'sh47 && winding_current.b == 8'sh47))
    else $error("half b diagonal wrong");

  monitor_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    angle_monitor_out == 1'b0)
    else $error("monitor drives high");

  monitor_pos_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (grid_pos == step_indexer_pkg::ANGLE_INIT) |=> angle_monitor_oe)
    else $error("monitor missed initial angle");

endmodule : stepper_step_indexer

// ===== host_model.sv
/*
  Host model: drives step pulses, direction and resolution pins.
  Assumes the caller is aligned to the rising edge of ref_clk.
*/
module host_model (
  input  wire logic       ref_clk,          // bench clock
  output logic            step_in,          // step pulse level
  output logic            direction_select, // high forward
  output logic [2:0]      res               // {b0,b1,b2}
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels
  initial begin
    step_in = 1'b0;
    direction_select = 1'b1;
    res = 3'h0;
  end
  // selects settle an edge before the rise and hold past the fall
  task automatic step(input logic d, input logic [2:0] r);
    @(posedge ref_clk);
    direction_select <= d;
    res <= r;
    @(posedge ref_clk) step_in <= 1'b1;
    @(posedge ref_clk) step_in <= 1'b0;
    @(posedge ref_clk);
  endtask : step
endmodule : host_model

// ===== tb_top.sv
/*
  Bench for the step indexer: random stepping, current corners, enable, faults, sleep.
  Assumes the designer's cycle figures; sleep and wake counts are shortened.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SLP = 8;
  localparam int WK  = 16;
  logic ref_clk, resetn, step_in, direction_select, output_enable, sleep_req_n, angle_reset;
  logic overtemp_shutdown, overcurrent_shutdown, angle_monitor_in, angle_monitor_out, angle_monitor_oe;
  logic fault_flag, output_stage_on, charge_pump_on, regulator_on, power_saving, e;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] res;
  logic [6:0] angle_position, exp_angle;
  logic [16:0] seed;
  step_indexer_pkg::winding_current_t winding_current;
  int err_count, num_checks;
  logic [15:0] cexp [7] = '{16'h5C26, 16'h4747, 16'h6464, 16'h6214, 16'h640A, 16'h9C64, 16'h6405};
  logic [2:0]  cres [7] = '{3'h3, 3'h2, 3'h1, 3'h4, 3'h5, 3'h0, 3'h6};
  // pull-up on the monitor wire
  assign angle_monitor_in = angle_monitor_oe ? angle_monitor_out : 1'b1;
  host_model host_model_inst (.ref_clk, .step_in, .direction_select, .res);
  stepper_step_indexer #(.SLEEP_CYCLES(SLP), .WAKE_CYCLES(WK)) stepper_step_indexer_inst (
    .ref_clk, .resetn, .step_in, .direction_select, .output_enable, .sleep_req_n, .angle_reset,
    .resolution_select_bit0(res[2]), .resolution_select_bit1(res[1]), .resolution_select_bit2(res[0]),
    .overtemp_shutdown, .overcurrent_shutdown, .angle_monitor_in, .angle_monitor_out, .angle_monitor_oe,
    .fault_flag, .output_stage_on, .charge_pump_on, .regulator_on, .power_saving, .winding_current,
    .angle_position, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    lfsr = {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr
  // fine steps per host step
  function automatic logic [6:0] sz(input logic [2:0] r);
    if (r[2]) sz = r[1] ? 7'h01 : (r[0] ? 7'h02 : 7'h04);
    else sz = (r[1:0] == 2'b00) ? 7'h20 : ((r[1:0] == 2'b11) ? 7'h08 : 7'h10);
  endfunction : sz
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask : settle
  // request held until pready is seen high at an edge
  // starts on an edge, so back-to-back calls never assign psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    do begin @(posedge ref_clk); end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic test_done;
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // watchdog, far beyond the expected run
  initial begin
    #25000;
    err_count++;
    test_done;
  end
  initial begin
    resetn = 0; output_enable = 1; sleep_req_n = 1; angle_reset = 0; overtemp_shutdown = 0;
    overcurrent_shutdown = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    exp_angle = 0; seed = 17'h11E77; err_count = 0; num_checks = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, step_indexer_pkg::CONTROL_OFFSET, 32'h0); chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0); chk(q, 32'h0); chk(e, 32'h1);
    // random direction and resolution; falling edges must not move the angle
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      host_model_inst.step(seed[4], seed[2:0]);
      exp_angle = seed[4] ? exp_angle + sz(seed[2:0]) : exp_angle - sz(seed[2:0]);
      settle; chk(angle_position, exp_angle);
    end
    // one step from the initial index in each of the seven modes
    for (int k = 0; k < 7; k++) begin
      @(posedge ref_clk) angle_reset <= 1'b1;
      @(posedge ref_clk) angle_reset <= 1'b0;
      settle;
      chk(angle_position, 32'h0);
      chk(angle_monitor_in, 32'h0);
      chk(angle_monitor_out, 32'h0);
      host_model_inst.step(1'b1, cres[k]); settle;
      chk(winding_current, cexp[k]);
      chk(angle_monitor_oe, 32'h0);
    end
    @(posedge ref_clk) output_enable <= 1'b0;
    settle; chk(output_stage_on, 32'h0);
    @(posedge ref_clk) output_enable <= 1'b1;
    settle; chk(output_stage_on, 32'h1);
    apb(1'b1, step_indexer_pkg::CONTROL_OFFSET, 32'h1); settle; chk(output_stage_on, 32'h0);
    apb(1'b0, step_indexer_pkg::CONTROL_OFFSET, 32'h0); chk(q, 32'h1);
    apb(1'b1, step_indexer_pkg::CONTROL_OFFSET, 32'h0);
    // each detector latches, then a sleep cycle clears it
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk) {overtemp_shutdown, overcurrent_shutdown} <= k ? 2'b01 : 2'b10;
      settle;
      @(posedge ref_clk) {overtemp_shutdown, overcurrent_shutdown} <= 2'b00;
      settle;
      chk(fault_flag, 32'h1);
      chk(output_stage_on, 32'h0);
      @(posedge ref_clk) sleep_req_n <= 1'b0;
      settle;
      chk({charge_pump_on, regulator_on}, 32'h0);
      repeat (SLP - 2) settle; chk(power_saving, 32'h0);
      repeat (3) settle; chk(power_saving, 32'h1);
      @(posedge ref_clk) sleep_req_n <= 1'b1;
      repeat (WK - 2) settle; chk(output_stage_on, 32'h0);
      repeat (4) settle; chk(output_stage_on, 32'h1);
      chk(fault_flag, 32'h0);
    end
    apb(1'b0, step_indexer_pkg::STATUS_OFFSET, 32'h0); chk(q[8], 32'h1);
    test_done;
  end
endmodule : tb_top
